/* verilog/csp_defines.svh */
// Purpose: constants of the codec serial port
// Assumes: included by bare name
// Notes: values are those of the port itself
`ifndef CSP_DEFINES_SVH
`define CSP_DEFINES_SVH
// ---------------------------------------------
// framing
// ---------------------------------------------
`define CSP_SAMPLE_W 16
`define CSP_FRAME_BITS 32
`define CSP_SCLK_DIV 4
`define CSP_PULSE_LOW 1
// ---------------------------------------------
// strap codes {hi, lo}
// ---------------------------------------------
`define CSP_MODE_LEVEL 2'b00
`define CSP_MODE_PULSE 2'b01
`define CSP_MODE_SLAVE 2'b10
`define CSP_MODE_RSVD 2'b11
// ---------------------------------------------
// secondary word, register file and strap settling
// ---------------------------------------------
`define CSP_REQ_BIT 0
`define CSP_RD_BIT 7
`define CSP_NREGS 32
`define CSP_REG_RST 8'h00
`define CSP_ADDR_PHASE 8
`define CSP_STRAP_SETTLE 2'h3
`endif

/* verilog/csp_pkg.sv */
// Purpose: types of the codec serial port
// Assumes: csp_defines.svh holds the numbers
// Notes: none
`include "csp_defines.svh"
package csp_pkg;
   // strap-selected framing
   typedef enum logic [1:0] {
      CSP_LEVEL = `CSP_MODE_LEVEL,
      CSP_PULSE = `CSP_MODE_PULSE,
      CSP_SLAVE = `CSP_MODE_SLAVE,
      CSP_RSVD = `CSP_MODE_RSVD
   } csp_mode_t;
   // link state, gray along wait-prim-sec
   typedef enum logic [1:0] {
      LK_WAIT = 2'b00,
      LK_PRIM = 2'b01,
      LK_SEC = 2'b11,
      LK_HALT = 2'b10
   } csp_state_t;
   // secondary-frame control word
   typedef struct packed {
      logic rd;
      logic [1:0] spare;
      logic [4:0] addr;
      logic [7:0] data;
   } csp_cmd_t;
   // strap pair
   typedef struct packed {
      logic hi;
      logic lo;
   } csp_strap_t;
endpackage

/* verilog/csp_serial_port.sv */
// Purpose: serial audio and control port of a voiceband codec
// Assumes: mclk is the link clock, 1 to 60 MHz; sample width 16
// Notes: bit clock is mclk divided by 2*SCLK_DIV
// Function
// - Two straps pick level framing, pulse framing, slave, or reserved.
// - Strap hi set with lo clear makes the port a slave on a shared chain.
// - Frame sync falls and rises once per frame; its fall starts a frame.
// - The port drives the serial bit clock that times every data bit.
// - Data is valid and sampled at falling bit clock edges after the start.
// - Host samples come in on the input line, codec samples go out.
// - A secondary frame carries register reads and writes.
`timescale 1ns/1ps
`include "csp_defines.svh"
module csp_serial_port #(
   parameter int SAMPLE_W = `CSP_SAMPLE_W,
   parameter int FRAME_BITS = `CSP_FRAME_BITS,
   parameter int SCLK_DIV = `CSP_SCLK_DIV
) (
   // clocks and reset
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic mclk,
   // mode straps
   input wire logic mode_strap_hi,
   input wire logic mode_strap_lo,
   // serial link pins
   output logic bit_clk,
   input wire logic frame_sync_in,
   output logic frame_sync_out,
   output logic frame_sync_oe,
   input wire logic serial_in_line,
   output logic serial_out_line,
   output logic serial_out_oe,
   // codec-side samples
   input wire logic [SAMPLE_W-1:0] adc_sample,
   input wire logic adc_valid,
   output logic adc_ready,
   output logic [SAMPLE_W-1:0] dac_sample,
   output logic dac_valid,
   // status
   output csp_pkg::csp_mode_t mode_sel,
   output logic mode_bad
);
   localparam int FW = $clog2(FRAME_BITS);
   localparam int DW = $clog2(SCLK_DIV + 1);
   localparam int PW_MAX = 2 * SCLK_DIV + 2;
   localparam logic [FW-1:0] LAST_BIT = FW'(FRAME_BITS - 1);
   localparam logic [FW-1:0] LAST_DATA = FW'(SAMPLE_W - 1);
   localparam logic [FW-1:0] ADDR_PH = FW'(`CSP_ADDR_PHASE);
   localparam logic [DW-1:0] DIV_TOP = DW'(SCLK_DIV - 1);

   // ---------------------------------------------
   // reference domain: straps and mode
   // ---------------------------------------------
   csp_pkg::csp_strap_t strap_m_r, strap_s_r;
   csp_pkg::csp_mode_t mode_r;
   logic [1:0] settle_r;
   logic mode_ok_r, mode_bad_r;

   // straps pass two flops before use
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         strap_m_r <= '0;
         strap_s_r <= '0;
      end else begin
         strap_m_r <= '{hi: mode_strap_hi, lo: mode_strap_lo};
         strap_s_r <= strap_m_r;
      end
   end

   // latch once the synchroniser has settled after release
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         settle_r <= 2'h0;
         mode_ok_r <= 1'b0;
         mode_r <= csp_pkg::CSP_LEVEL;
         mode_bad_r <= 1'b0;
      end else if (!mode_ok_r) begin
         settle_r <= settle_r + 2'h1;
         if (settle_r == `CSP_STRAP_SETTLE) begin
            mode_ok_r <= 1'b1;
            mode_r <= csp_pkg::csp_mode_t'(strap_s_r);
            mode_bad_r <= (strap_s_r == `CSP_MODE_RSVD);
         end
      end
   end

   // ---------------------------------------------
   // reference domain: sample handshakes
   // ---------------------------------------------
   logic adc_req_r, adc_ack_m_r, adc_ack_s_r, adc_ready_r;
   logic [SAMPLE_W-1:0] adc_hold_r, dac_hold_r, dac_sample_r;
   logic dac_t_m_r, dac_t_s_r, dac_t_d_r, dac_valid_r;
   logic adc_ack_r, dac_tgl_r;
   logic adc_take;
   assign adc_take = adc_valid && adc_ready_r;

   // hold word stays put until the link acknowledges
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         adc_req_r <= 1'b0;
         adc_hold_r <= '0;
         adc_ack_m_r <= 1'b0;
         adc_ack_s_r <= 1'b0;
         adc_ready_r <= 1'b0;
      end else begin
         adc_ack_m_r <= adc_ack_r;
         adc_ack_s_r <= adc_ack_m_r;
         if (adc_take) begin
            adc_req_r <= ~adc_req_r;
            adc_hold_r <= adc_sample;
         end
         adc_ready_r <= mode_ok_r && !adc_take && (adc_req_r == adc_ack_s_r);
      end
   end

   // received word is stable for a frame, so a toggle suffices
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         dac_t_m_r <= 1'b0;
         dac_t_s_r <= 1'b0;
         dac_t_d_r <= 1'b0;
         dac_valid_r <= 1'b0;
         dac_sample_r <= '0;
      end else begin
         dac_t_m_r <= dac_tgl_r;
         dac_t_s_r <= dac_t_m_r;
         dac_t_d_r <= dac_t_s_r;
         dac_valid_r <= (dac_t_s_r != dac_t_d_r);
         if (dac_t_s_r != dac_t_d_r) begin
            dac_sample_r <= dac_hold_r;
         end
      end
   end

   // ---------------------------------------------
   // link domain: reset and crossings in
   // ---------------------------------------------
   logic lrst_m_r, lrst_r;
   logic ok_m_r, ok_s_r;
   csp_pkg::csp_mode_t mode_s_r;
   logic rq_m_r, rq_s_r;
   logic fs_m_r, fs_s_r, fs_d_r, sin_m_r, sin_s_r;

   // asserted at once, released on mclk
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         lrst_m_r <= 1'b1;
         lrst_r <= 1'b1;
      end else begin
         lrst_m_r <= 1'b0;
         lrst_r <= lrst_m_r;
      end
   end

   // levels and pins into the link domain
   always_ff @(posedge mclk or posedge lrst_r) begin
      if (lrst_r) begin
         ok_m_r <= 1'b0;
         ok_s_r <= 1'b0;
         mode_s_r <= csp_pkg::CSP_LEVEL;
         rq_m_r <= 1'b0;
         rq_s_r <= 1'b0;
         fs_m_r <= 1'b1;
         fs_s_r <= 1'b1;
         fs_d_r <= 1'b1;
         sin_m_r <= 1'b0;
         sin_s_r <= 1'b0;
      end else begin
         ok_m_r <= mode_ok_r;
         ok_s_r <= ok_m_r;
         // mode is steady by the time its qualifier lands, so take it whole then;
         // two bits synced apart could disagree for a cycle
         if (ok_m_r && !ok_s_r) begin
            mode_s_r <= mode_r;
         end
         rq_m_r <= adc_req_r;
         rq_s_r <= rq_m_r;
         fs_m_r <= frame_sync_in;
         fs_s_r <= fs_m_r;
         fs_d_r <= fs_s_r;
         sin_m_r <= serial_in_line;
         sin_s_r <= sin_m_r;
      end
   end

   // ---------------------------------------------
   // link domain: bit clock and framing
   // ---------------------------------------------
   csp_pkg::csp_state_t state_r;
   logic [DW-1:0] div_r;
   logic [FW-1:0] bit_r;
   logic bclk_r, fs_out_r, fs_oe_r, slv_pend_r, sec_req_r;
   logic tick, rise_ev, fall_ev, running, master, frame_start;
   logic [FW-1:0] low_bits;
   assign running = (state_r == csp_pkg::LK_PRIM) || (state_r == csp_pkg::LK_SEC);
   assign master = (mode_s_r != csp_pkg::CSP_SLAVE);
   assign tick = running && (div_r == DIV_TOP);
   assign rise_ev = tick && !bclk_r;
   assign fall_ev = tick && bclk_r;
   assign frame_start = rise_ev && (master ? (bit_r == LAST_BIT) : slv_pend_r);
   assign low_bits = (mode_s_r == csp_pkg::CSP_PULSE) ? FW'(`CSP_PULSE_LOW) : LAST_DATA + 1'b1;

   // divider makes the bit clock from mclk
   always_ff @(posedge mclk or posedge lrst_r) begin
      if (lrst_r) begin
         div_r <= '0;
         bclk_r <= 1'b0;
      end else if (running) begin
         div_r <= tick ? '0 : div_r + 1'b1;
         if (tick) begin
            bclk_r <= ~bclk_r;
         end
      end
   end

   // slave frames follow a falling sync from upstream
   always_ff @(posedge mclk or posedge lrst_r) begin
      if (lrst_r) begin
         slv_pend_r <= 1'b0;
      end else if (fs_d_r && !fs_s_r && !master) begin
         slv_pend_r <= 1'b1;
      end else if (rise_ev) begin
         slv_pend_r <= 1'b0;
      end
   end

   // frame state and bit position
   always_ff @(posedge mclk or posedge lrst_r) begin
      if (lrst_r) begin
         state_r <= csp_pkg::LK_WAIT;
         bit_r <= '0;
         fs_oe_r <= 1'b0;
      end else begin
         case (state_r)
            csp_pkg::LK_WAIT: begin
               if (ok_s_r) begin
                  // reserved code never starts the link
                  state_r <= (mode_s_r == csp_pkg::CSP_RSVD) ?
                     csp_pkg::LK_HALT : csp_pkg::LK_PRIM;
                  fs_oe_r <= (mode_s_r == csp_pkg::CSP_LEVEL) ||
                     (mode_s_r == csp_pkg::CSP_PULSE);
                  bit_r <= LAST_BIT;
               end
            end
            csp_pkg::LK_PRIM, csp_pkg::LK_SEC: begin
               if (frame_start) begin
                  bit_r <= '0;
                  state_r <= (state_r == csp_pkg::LK_PRIM && sec_req_r) ?
                     csp_pkg::LK_SEC : csp_pkg::LK_PRIM;
               end else if (rise_ev && bit_r != LAST_BIT) begin
                  bit_r <= bit_r + 1'b1;
               end
            end
            csp_pkg::LK_HALT: begin
               state_r <= csp_pkg::LK_HALT;
            end
            default: begin
               state_r <= csp_pkg::LK_WAIT;
            end
         endcase
      end
   end

   // sync falls at frame start, rises after the low span
   always_ff @(posedge mclk or posedge lrst_r) begin
      if (lrst_r) begin
         fs_out_r <= 1'b1;
      end else if (frame_start && master) begin
         fs_out_r <= 1'b0;
      end else if (rise_ev && bit_r + 1'b1 == low_bits) begin
         fs_out_r <= 1'b1;
      end
   end

   // ---------------------------------------------
   // link domain: data shifting and registers
   // ---------------------------------------------
   logic [SAMPLE_W-1:0] tx_r, out_sh_r, in_sh_r, out_nxt, word_in;
   logic [7:0] regs_r [`CSP_NREGS];
   logic sout_r, sout_oe_r, wr_ev_r;
   csp_pkg::csp_cmd_t cmd;
   assign word_in = {in_sh_r[SAMPLE_W-2:0], sin_s_r};
   assign cmd = csp_pkg::csp_cmd_t'(word_in);

   // next output word, read data spliced in after the address byte
   always_comb begin
      out_nxt = out_sh_r << 1;
      if (state_r == csp_pkg::LK_SEC && bit_r + 1'b1 == ADDR_PH && in_sh_r[`CSP_RD_BIT]) begin
         out_nxt[SAMPLE_W-1 -: 8] = regs_r[in_sh_r[4:0]];
      end
   end

   // drive on rising edges so data is settled at the fall
   always_ff @(posedge mclk or posedge lrst_r) begin
      if (lrst_r) begin
         tx_r <= '0;
         out_sh_r <= '0;
         sout_r <= 1'b0;
         sout_oe_r <= 1'b0;
         adc_ack_r <= 1'b0;
      end else if (frame_start) begin
         sout_oe_r <= 1'b1;
         if (state_r == csp_pkg::LK_PRIM && sec_req_r) begin
            out_sh_r <= '0;
            sout_r <= 1'b0;
         end else if (rq_s_r != adc_ack_r) begin
            adc_ack_r <= rq_s_r;
            tx_r <= adc_hold_r;
            out_sh_r <= adc_hold_r;
            sout_r <= adc_hold_r[SAMPLE_W-1];
         end else begin
            out_sh_r <= tx_r; // repeat last sample when none is new
            sout_r <= tx_r[SAMPLE_W-1];
         end
      end else if (rise_ev) begin
         out_sh_r <= out_nxt;
         sout_r <= out_nxt[SAMPLE_W-1];
         if (bit_r == LAST_DATA) begin
            sout_oe_r <= 1'b0; // frees the shared line
         end
      end
   end

   // sample the input at falling edges of the bit clock
   always_ff @(posedge mclk or posedge lrst_r) begin
      if (lrst_r) begin
         in_sh_r <= '0;
         dac_hold_r <= '0;
         dac_tgl_r <= 1'b0;
         sec_req_r <= 1'b0;
         wr_ev_r <= 1'b0;
      end else begin
         wr_ev_r <= 1'b0;
         if (fall_ev && bit_r <= LAST_DATA) begin
            in_sh_r <= word_in;
            if (bit_r == LAST_DATA && state_r == csp_pkg::LK_PRIM) begin
               dac_hold_r <= word_in;
               dac_tgl_r <= ~dac_tgl_r;
               sec_req_r <= word_in[`CSP_REQ_BIT];
            end else if (bit_r == LAST_DATA) begin
               sec_req_r <= 1'b0;
               wr_ev_r <= !cmd.rd;
            end
         end
      end
   end

   // control registers, cleared by reset
   always_ff @(posedge mclk or posedge lrst_r) begin
      if (lrst_r) begin
         for (int i = 0; i < `CSP_NREGS; i++) begin
            regs_r[i] <= `CSP_REG_RST;
         end
      end else if (fall_ev && bit_r == LAST_DATA && state_r == csp_pkg::LK_SEC && !cmd.rd) begin
         regs_r[cmd.addr] <= cmd.data;
      end
   end

   // ---------------------------------------------
   // outputs
   // ---------------------------------------------
   assign bit_clk = bclk_r;
   assign frame_sync_out = fs_out_r;
   assign frame_sync_oe = fs_oe_r;
   assign serial_out_line = sout_r;
   assign serial_out_oe = sout_oe_r;
   assign adc_ready = adc_ready_r;
   assign dac_sample = dac_sample_r;
   assign dac_valid = dac_valid_r;
   assign mode_sel = mode_r;
   assign mode_bad = mode_bad_r;

   // ---------------------------------------------
   // assertions
   // ---------------------------------------------
   logic [4:0] wr_addr_r;
   logic [7:0] wr_data_r;
   // helper copy of the address and data fields of the last received word, for checking
   always_ff @(posedge mclk or posedge lrst_r) begin
      if (lrst_r) begin
         wr_addr_r <= '0;
         wr_data_r <= '0;
      end else if (fall_ev && bit_r == LAST_DATA) begin
         wr_addr_r <= cmd.addr;
         wr_data_r <= cmd.data;
      end
   end

   sequence s_frame_begin;
      frame_start && master;
   endsequence
   sequence s_sec_write;
      wr_ev_r ##0 (state_r == csp_pkg::LK_SEC);
   endsequence

   mode_hold_a: assert property (@(posedge ref_clk) disable iff (rst)
      mode_ok_r |=> $stable(mode_r) && mode_ok_r)
      else $error("mode changed after latch");
   strap_latch_a: assert property (@(posedge ref_clk) disable iff (rst)
      $rose(mode_ok_r) |-> mode_r == csp_pkg::csp_mode_t'($past(strap_s_r)))
      else $error("mode not taken from straps");
   slave_quiet_a: assert property (@(posedge mclk) disable iff (lrst_r)
      (running && mode_s_r == csp_pkg::CSP_SLAVE) |-> !fs_oe_r)
      else $error("slave drives frame sync");
   frame_fall_a: assert property (@(posedge mclk) disable iff (lrst_r)
      s_frame_begin |=> !fs_out_r && bit_r == '0)
      else $error("frame start without sync fall");
   pulse_width_a: assert property (@(posedge mclk) disable iff (lrst_r)
      ($fell(fs_out_r) && mode_s_r == csp_pkg::CSP_PULSE) |-> ##[1:PW_MAX] fs_out_r)
      else $error("pulse sync too long");
   bclk_toggle_a: assert property (@(posedge mclk) disable iff (lrst_r)
      tick |=> bclk_r != $past(bclk_r))
      else $error("bit clock missed a toggle");
   out_on_rise_a: assert property (@(posedge mclk) disable iff (lrst_r)
      $changed(sout_r) |-> $past(rise_ev))
      else $error("output moved off a rising edge");
   dac_deliver_a: assert property (@(posedge ref_clk) disable iff (rst)
      (dac_t_s_r != dac_t_d_r) |=> dac_valid_r && dac_sample_r == $past(dac_hold_r))
      else $error("received sample not delivered");
   reg_write_a: assert property (@(posedge mclk) disable iff (lrst_r)
      s_sec_write |-> regs_r[wr_addr_r] == wr_data_r)
      else $error("register write lost");
endmodule

/* dv/csp_dsp_model.sv */
// Purpose: behavioural host serial port facing the codec serial port
// Assumes: bit clock comes from the codec; frames are 32 bit periods
// Notes: unused bit slots carry a toggling pattern, never the last bit
`timescale 1ns/1ps
module csp_dsp_model (
   // reset and link pins
   input wire logic rst,
   input wire logic bit_clk,
   input wire logic frame_sync_out,
   input wire logic frame_sync_oe,
   input wire logic serial_out_line,
   input wire logic serial_out_oe,
   input wire logic slave_mode,
   output logic serial_in_line,
   output logic frame_sync_in,
   // bench side
   input wire logic [15:0] tx_word,
   output logic [15:0] rx_word,
   output int loads,
   output int low_cnt,
   output int frame_len
);
   logic [15:0] hold;
   logic [15:0] sh;
   logic prev_fs;
   logic start;
   int k;
   int sc;
   int lows;
   int len;
   // ---------------------------------------------
   // upstream sync, lowered a bit and a half ahead of the detect
   // ---------------------------------------------
   always @(posedge bit_clk or posedge rst) begin
      if (rst) begin
         frame_sync_in <= 1'b1;
      end else begin
         frame_sync_in <= !(slave_mode && sc == 31);
      end
   end
   // ---------------------------------------------
   // frame tracking, capture and drive at bit clock falls
   // ---------------------------------------------
   always @(negedge bit_clk or posedge rst) begin
      if (rst) begin
         k = 32;
         sc = 1;
         prev_fs = 1'b1;
         lows = 0;
         len = 0;
         loads = 0;
         low_cnt = 0;
         frame_len = 0;
         hold = tx_word;
         rx_word <= 16'h0000;
         serial_in_line <= tx_word[15];
      end else begin
         start = slave_mode ? (sc == 0) : (frame_sync_oe && !frame_sync_out && prev_fs);
         prev_fs = frame_sync_out;
         sc = (sc + 1) % 32;
         len++;
         if (start) begin
            frame_len = len;
            low_cnt = lows;
            len = 0;
            lows = 0;
            k = 0;
         end else if (k < 32) begin
            k++;
         end
         if (frame_sync_oe && !frame_sync_out) lows++;
         // codec word arrives msb first on falls; a released line reads inverted
         if (k < 16) begin
            sh = {sh[14:0], serial_out_oe ? serial_out_line : ~serial_out_line};
         end
         if (k == 15) rx_word <= sh;
         // next host bit set right after a fall, so it has a whole bit to settle before the next fall samples it
         if (k < 15) begin
            serial_in_line <= hold[14-k];
         end else if (k == 31) begin
            hold = tx_word;
            loads++;
            serial_in_line <= tx_word[15];
         end else if (k < 31) begin
            serial_in_line <= ~serial_in_line;
         end
      end
   end
endmodule

/* dv/tb_codec_serial_port_modes.sv */
// Purpose: self-checking bench of the codec serial port in every strap mode
// Assumes: host model in csp_dsp_model; link clock 80 ns
// Notes: reset held three link cycles so both domains see it
`timescale 1ns/1ps
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin mismatches++; \
   $display("BAD t=%0t got %h want %h", $time, (a), (b)); end end
module tb_codec_serial_port_modes;
   logic ref_clk = 1'b0;
   logic mclk = 1'b0;
   logic rst = 1'b1;
   logic mode_strap_hi = 1'b0;
   logic mode_strap_lo = 1'b0;
   logic slave = 1'b0;
   logic adc_valid = 1'b0;
   logic [15:0] adc_sample = 16'h0000;
   logic [15:0] tx_word = 16'h0000;
   logic bit_clk, frame_sync_in, frame_sync_out, frame_sync_oe;
   logic serial_in_line, serial_out_line, serial_out_oe;
   logic adc_ready, dac_valid, mode_bad;
   logic [15:0] dac_sample, rx_word;
   csp_pkg::csp_mode_t mode_sel;
   int loads, low_cnt, frame_len;
   int mismatches = 0;
   int checks_done = 0;
   int dac_pulses = 0;
   // ---------------------------------------------
   // clocks: system 5 ns, link 80 ns free running, odd phase
   // ---------------------------------------------
   initial begin
      forever #2.5 ref_clk = ~ref_clk;
   end
   initial begin
      #17;
      forever #40 mclk = ~mclk;
   end
   csp_serial_port i_dut (.ref_clk(ref_clk), .rst(rst), .mclk(mclk),
      .mode_strap_hi(mode_strap_hi), .mode_strap_lo(mode_strap_lo), .bit_clk(bit_clk),
      .frame_sync_in(frame_sync_in), .frame_sync_out(frame_sync_out),
      .frame_sync_oe(frame_sync_oe), .serial_in_line(serial_in_line),
      .serial_out_line(serial_out_line), .serial_out_oe(serial_out_oe),
      .adc_sample(adc_sample), .adc_valid(adc_valid), .adc_ready(adc_ready),
      .dac_sample(dac_sample), .dac_valid(dac_valid), .mode_sel(mode_sel),
      .mode_bad(mode_bad));
   csp_dsp_model i_dsp (.rst(rst), .bit_clk(bit_clk), .frame_sync_out(frame_sync_out),
      .frame_sync_oe(frame_sync_oe), .serial_out_line(serial_out_line),
      .serial_out_oe(serial_out_oe), .slave_mode(slave),
      .serial_in_line(serial_in_line), .frame_sync_in(frame_sync_in), .tx_word(tx_word),
      .rx_word(rx_word), .loads(loads), .low_cnt(low_cnt), .frame_len(frame_len));
   // received-word strobes, counted away from the edge that launches them
   always @(negedge ref_clk) begin
      if (dac_valid === 1'b1) dac_pulses++;
   end
   // ---------------------------------------------
   // shared tasks
   // ---------------------------------------------
   task automatic close_out();
      $display("counts: %0d checks, %0d mismatches", checks_done, mismatches);
      if (mismatches == 0 && checks_done > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask
   task automatic give_up();
      mismatches++;
      $display("BAD t=%0t wait ran out", $time);
      close_out();
   endtask
   task automatic do_reset(input logic hi, input logic lo, input logic sl);
      @(negedge ref_clk);
      rst = 1'b1;
      mode_strap_hi = hi;
      mode_strap_lo = lo;
      slave = sl;
      tx_word = 16'h0000;
      repeat (48) @(negedge ref_clk);
      `CHK({bit_clk, frame_sync_out, frame_sync_oe, serial_out_oe}, 4'h4)
      `CHK({adc_ready, dac_valid, mode_sel}, 4'h0)
      rst = 1'b0;
      // link needs about six mclk edges to cross the mode and start
      repeat (160) @(negedge ref_clk);
   endtask
   // word handed to the host model; returns once it is queued for the next frame
   task automatic put(input logic [15:0] w);
      int n;
      int i;
      tx_word = w;
      n = loads;
      for (i = 0; i < 12000 && loads == n; i++) @(negedge ref_clk);
      if (loads == n) give_up();
   endtask
   task automatic send_adc(input logic [15:0] s);
      int i;
      @(negedge ref_clk);
      adc_sample = s;
      adc_valid = 1'b1;
      for (i = 0; i < 2000 && adc_ready !== 1'b1; i++) @(negedge ref_clk);
      if (adc_ready !== 1'b1) give_up();
      @(negedge ref_clk);
      adc_valid = 1'b0;
   endtask
   // ---------------------------------------------
   // scenarios
   // ---------------------------------------------
   task automatic t_level();
      int p;
      do_reset(1'b0, 1'b0, 1'b0);
      `CHK(mode_sel, csp_pkg::CSP_LEVEL)
      `CHK({frame_sync_oe, mode_bad}, 2'h2)
      send_adc(16'hbeef);
      put(16'ha5c2);
      put(16'ha5c2);
      p = dac_pulses;
      put(16'h0000);
      `CHK(dac_pulses - p, 1)
      `CHK(rx_word, 16'hbeef)
      `CHK(dac_sample, 16'ha5c2)
      `CHK(low_cnt, 16)
      `CHK(frame_len, 32)
      $display("level framing test done");
   endtask
   task automatic t_hold();
      @(negedge ref_clk);
      mode_strap_lo = 1'b1;
      repeat (300) @(negedge ref_clk);
      `CHK(mode_sel, csp_pkg::CSP_LEVEL)
      put(16'h0000);
      put(16'h0000);
      `CHK(low_cnt, 16)
      $display("strap hold test done");
   endtask
   task automatic t_regs();
      // request, write top register, read it back, then read a reset value
      put(16'h1235);
      put(16'h1f3c);
      put(16'h1235);
      put(16'h9f00);
      put(16'h1235);
      `CHK(rx_word, 16'h003c)
      put(16'h8000);
      put(16'h0000);
      `CHK(rx_word, 16'h0000)
      `CHK(dac_sample, 16'h1235)
      $display("register frame test done");
   endtask
   task automatic t_pulse();
      do_reset(1'b0, 1'b1, 1'b0);
      `CHK(mode_sel, csp_pkg::CSP_PULSE)
      put(16'h4444);
      put(16'h4444);
      put(16'h0000);
      `CHK(low_cnt, 1)
      `CHK(frame_len, 32)
      `CHK(dac_sample, 16'h4444)
      $display("pulse framing test done");
   endtask
   task automatic t_slave();
      do_reset(1'b1, 1'b0, 1'b1);
      `CHK(mode_sel, csp_pkg::CSP_SLAVE)
      `CHK(frame_sync_oe, 1'b0)
      send_adc(16'h7e81);
      put(16'h6a6a);
      put(16'h6a6a);
      put(16'h0000);
      `CHK(rx_word, 16'h7e81)
      `CHK(dac_sample, 16'h6a6a)
      $display("slave test done");
   endtask
   task automatic t_rsvd();
      int i;
      int act;
      do_reset(1'b1, 1'b1, 1'b0);
      `CHK(mode_sel, csp_pkg::CSP_RSVD)
      `CHK(mode_bad, 1'b1)
      act = 0;
      for (i = 0; i < 2000; i++) begin
         @(negedge ref_clk);
         if (bit_clk !== 1'b0 || serial_out_oe !== 1'b0) act++;
      end
      `CHK(act, 0)
      $display("reserved code test done");
   endtask
   // ---------------------------------------------
   // main sequence
   // ---------------------------------------------
   initial begin
      t_level();
      t_hold();
      t_regs();
      t_pulse();
      t_slave();
      t_rsvd();
      close_out();
   end
endmodule
